/* File: logic/csc_regs.vh */
`ifndef CSC_REGS_VH
`define CSC_REGS_VH

// Register indexes
`define CSC_IDX_IDENT        8'h00
`define CSC_IDX_STATUS       8'h01
`define CSC_IDX_POWER        8'h02

// Power and reset control fields
`define CSC_PWR_OUT_EN       7
`define CSC_PWR_KEEP_ON_RST  6
`define CSC_PWR_AUTO_SW      5
`define CSC_PWR_VCC_ON       4
`define CSC_PWR_VPP_HI       1
`define CSC_PWR_VPP_LO       0
`define CSC_PWR_RESET        8'h00

// Interface status fields
`define CSC_ST_GPI           7
`define CSC_ST_POWER         6
`define CSC_ST_READY         5
`define CSC_ST_WP            4
`define CSC_ST_CD2           3
`define CSC_ST_CD1           2
`define CSC_ST_BVD2          1
`define CSC_ST_BVD1          0

// Identification fields
`define CSC_ID_TYPE_MSB      7
`define CSC_ID_TYPE_LSB      6
`define CSC_ID_REV_MSB       3
`define CSC_ID_REV_LSB       0

// Card request source select
`define CSC_REQ_NONE         2'h0
`define CSC_REQ_IOIS16       2'h1
`define CSC_REQ_SPKR         2'h2
`define CSC_REQ_INPACK       2'h3

// Supply select encodings
`define CSC_VPP_OFF_STATE    2'h0
`define CSC_VPP_BIT4_LOW     2'h2

// Synchronised pin vector positions
`define CSC_PIN_GPI          0
`define CSC_PIN_CD1_N        1
`define CSC_PIN_CD2_N        2
`define CSC_PIN_READY        3
`define CSC_PIN_WP_IOIS16_N  4
`define CSC_PIN_SPKR_N       5
`define CSC_PIN_INPACK_N     6
`define CSC_PIN_BVD1_STSCHG  7
`define CSC_PIN_BVD2         8
`define CSC_PIN_DACK_N       9
`define CSC_PIN_TC11_N       10
`define CSC_PIN_TC15_N       11
`define CSC_PIN_RESET_DRIVE  12
`define CSC_PIN_POWER_GOOD   13
`define CSC_PIN_COUNT        14

`endif

/* File: logic/csc_slot_control.v */
`timescale 1ns/1ps
`include "csc_regs.vh"

module csc_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output reg              in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    reg [AW:0]      next_count;
    wire            push;
    wire            pop;

    assign push = in_valid && in_ready;
    // Refill output stage when empty or being drained
    assign pop  = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

    always @*
    begin
        next_count = count;
        if (push && !pop)
            next_count = count + {{AW{1'b0}}, 1'b1};
        else if (pop && !push)
            next_count = count - {{AW{1'b0}}, 1'b1};
    end

    always @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end
        else
        begin
            count    <= next_count;
            in_ready <= (next_count < DEPTH);
            if (push)
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
            begin
                out_data  <= mem[rd_ptr];
                out_valid <= 1'b1;
                rd_ptr    <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            else if (out_ready)
                out_valid <= 1'b0;
        end
    end
endmodule // csc_fifo

module csc_slot_control #(
    parameter [1:0] CARD_TYPES = 2'h2,
    parameter [3:0] REVISION   = 4'h1,   // Arbitrary value
    parameter       DATA_WIDTH = 16,
    parameter       FIFO_DEPTH = 32,
    parameter       FIFO_AW    = 5
) (
    input  wire                  SYS_CLK,
    input  wire                  RESET_N,
    // Register port
    input  wire [7:0]            REG_INDEX,
    input  wire                  REG_WRITE,
    input  wire                  REG_READ,
    input  wire [7:0]            REG_WDATA,
    output reg  [7:0]            REG_RDATA,
    // Mode bits held in other register groups
    input  wire                  DMA_MODE_ENABLE,
    input  wire [1:0]            DMA_REQ_SELECT,
    input  wire                  TC_SELECT_IRQ15,
    input  wire                  IO_CARD,
    input  wire                  RING_INDICATE_ENABLE,
    input  wire                  WRITE_PROTECT_ENABLE,
    input  wire                  MIXED_VOLTAGE,
    input  wire                  WIDE_TRANSFER,
    input  wire                  DMA_CARD_READ,
    input  wire                  NORMAL_REG_N,
    // Asynchronous pins
    input  wire                  GENERAL_PURPOSE_INPUT,
    input  wire                  CD1_N,
    input  wire                  CD2_N,
    input  wire                  READY_IREQ,
    input  wire                  WP_IOIS16_N,
    input  wire                  SPKR_N,
    input  wire                  INPACK_N,
    input  wire                  BVD1_STSCHG,
    input  wire                  BVD2,
    input  wire                  IRQ9_IN,
    input  wire                  IRQ11_IN,
    input  wire                  IRQ15_IN,
    input  wire                  RESET_DRIVE,
    input  wire                  POWER_GOOD,
    // DMA pins and slot strobes
    output reg                   IRQ10_OUT,
    output reg                   IRQ10_OE_N,
    output reg                   CARD_OE_N,
    output reg                   CARD_WE_N,
    output reg                   CARD_REG_N,
    output reg                   SLOT_OUT_EN_N,
    output reg                   SPEAKER_OUT_N,
    output reg                   MEM_WRITE_BLOCK,
    // Supplies
    output reg                   LOW_SUPPLY_ENABLE_N,
    output reg                   HIGH_SUPPLY_ENABLE_N,
    output reg                   PROG_SUPPLY_SELECT_HI,
    output reg                   PROG_SUPPLY_SELECT_LO,
    // DMA data path, card to system
    input  wire [DATA_WIDTH-1:0] DMA_IN_DATA,
    input  wire                  DMA_IN_VALID,
    output wire                  DMA_IN_READY,
    output wire [DATA_WIDTH-1:0] DMA_OUT_DATA,
    output wire                  DMA_OUT_VALID,
    input  wire                  DMA_OUT_READY
);
    reg  [`CSC_PIN_COUNT-1:0] pin_meta;
    reg  [`CSC_PIN_COUNT-1:0] pin_sync;
    reg                       reset_drive_prev;
    reg  [7:0]                power_ctrl;
    reg                       card_req;
    reg                       fifo_ready;
    reg  [7:0]                status;
    reg                       tc_active;
    reg                       dack_active;
    reg                       vcc_n;
    reg  [1:0]                vpp;
    wire [`CSC_PIN_COUNT-1:0] pins_raw;
    wire                      reset_drive_fall;
    wire                      load_defaults;
    wire                      supply_allowed;
    wire [DATA_WIDTH-1:0]     sized_data;

    assign pins_raw = {POWER_GOOD, RESET_DRIVE, IRQ15_IN, IRQ11_IN, IRQ9_IN, BVD2, BVD1_STSCHG,
                       INPACK_N, SPKR_N, WP_IOIS16_N, READY_IREQ, CD2_N, CD1_N, GENERAL_PURPOSE_INPUT};

    always @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pin_meta <= {`CSC_PIN_COUNT{1'b0}};
            pin_sync <= {`CSC_PIN_COUNT{1'b0}};
        end
        else
        begin
            pin_meta <= pins_raw;
            pin_sync <= pin_meta;
        end
    end

    assign reset_drive_fall = reset_drive_prev && !pin_sync[`CSC_PIN_RESET_DRIVE];
    // Resume reset kept off only with power good
    assign load_defaults = reset_drive_fall &&
        !(power_ctrl[`CSC_PWR_KEEP_ON_RST] && pin_sync[`CSC_PIN_POWER_GOOD]);

    always @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            reset_drive_prev <= 1'b0;
            power_ctrl       <= `CSC_PWR_RESET;
        end
        else
        begin
            reset_drive_prev <= pin_sync[`CSC_PIN_RESET_DRIVE];
            if (load_defaults)
                power_ctrl <= `CSC_PWR_RESET;
            else if (REG_WRITE && REG_INDEX == `CSC_IDX_POWER)
                power_ctrl <= REG_WDATA;
        end
    end

    // Card request source and terminal count
    always @*
    begin
        case (DMA_REQ_SELECT)
            `CSC_REQ_IOIS16: card_req = !pin_sync[`CSC_PIN_WP_IOIS16_N];
            `CSC_REQ_SPKR:   card_req = !pin_sync[`CSC_PIN_SPKR_N];
            `CSC_REQ_INPACK: card_req = !pin_sync[`CSC_PIN_INPACK_N];
            default:         card_req = 1'b0;
        endcase
        tc_active   = TC_SELECT_IRQ15 ? !pin_sync[`CSC_PIN_TC15_N] : !pin_sync[`CSC_PIN_TC11_N];
        dack_active = DMA_MODE_ENABLE && !pin_sync[`CSC_PIN_DACK_N];
    end

    // Supply decode
    assign supply_allowed = !power_ctrl[`CSC_PWR_AUTO_SW] ||
        (!pin_sync[`CSC_PIN_CD1_N] && !pin_sync[`CSC_PIN_CD2_N]);

    always @*
    begin
        if (!supply_allowed)
        begin
            vcc_n = 1'b1;
            vpp   = `CSC_VPP_OFF_STATE;
        end
        else if (power_ctrl[`CSC_PWR_VCC_ON])
        begin
            vcc_n = !MIXED_VOLTAGE;
            vpp   = power_ctrl[`CSC_PWR_VPP_HI:`CSC_PWR_VPP_LO];
        end
        else
        begin
            vcc_n = 1'b1;
            vpp   = `CSC_VPP_BIT4_LOW;
        end
    end

    // True when DMA mode has redefined this request source
    function src_selected;
        input       mode;
        input [1:0] sel;
        input [1:0] code;
        begin
            src_selected = mode && (sel == code);
        end
    endfunction

    // Interface status
    always @*
    begin
        status = 8'h00;
        status[`CSC_ST_GPI]   = !pin_sync[`CSC_PIN_GPI];
        status[`CSC_ST_POWER] = !LOW_SUPPLY_ENABLE_N || !HIGH_SUPPLY_ENABLE_N;
        status[`CSC_ST_READY] = pin_sync[`CSC_PIN_READY];
        if (src_selected(DMA_MODE_ENABLE, DMA_REQ_SELECT, `CSC_REQ_IOIS16))
            status[`CSC_ST_WP] = !pin_sync[`CSC_PIN_WP_IOIS16_N];
        else
            status[`CSC_ST_WP] = pin_sync[`CSC_PIN_WP_IOIS16_N];
        status[`CSC_ST_CD2] = !pin_sync[`CSC_PIN_CD2_N];
        status[`CSC_ST_CD1] = !pin_sync[`CSC_PIN_CD1_N];
        if (!IO_CARD)
        begin
            status[`CSC_ST_BVD2] = pin_sync[`CSC_PIN_BVD2];
            status[`CSC_ST_BVD1] = pin_sync[`CSC_PIN_BVD1_STSCHG];
        end
        else if (!RING_INDICATE_ENABLE)
            status[`CSC_ST_BVD1] = pin_sync[`CSC_PIN_BVD1_STSCHG];
    end

    // Register read data
    always @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            REG_RDATA <= 8'h00;
        end
        else
        begin
            if (REG_READ)
            begin
                case (REG_INDEX)
                    `CSC_IDX_IDENT:  REG_RDATA <= {CARD_TYPES, 2'h0, REVISION};
                    `CSC_IDX_STATUS: REG_RDATA <= status;
                    `CSC_IDX_POWER:  REG_RDATA <= power_ctrl;
                    default:         REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // DMA pin redefinitions and slot strobes
    always @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            IRQ10_OUT       <= 1'b0;
            IRQ10_OE_N      <= 1'b1;
            CARD_OE_N       <= 1'b1;
            CARD_WE_N       <= 1'b1;
            CARD_REG_N      <= 1'b1;
            SLOT_OUT_EN_N   <= 1'b1;
            SPEAKER_OUT_N   <= 1'b1;
            MEM_WRITE_BLOCK <= 1'b0;
            fifo_ready      <= 1'b0;
        end
        else
        begin
            fifo_ready <= DMA_IN_READY;
            // Request withheld while the buffer is full
            IRQ10_OUT  <= DMA_MODE_ENABLE && card_req && fifo_ready;
            IRQ10_OE_N <= !DMA_MODE_ENABLE;
            CARD_OE_N  <= !(dack_active && tc_active && DMA_CARD_READ);
            CARD_WE_N  <= !(dack_active && tc_active && !DMA_CARD_READ);
            CARD_REG_N <= DMA_MODE_ENABLE ? 1'b1 : NORMAL_REG_N;
            SLOT_OUT_EN_N <= !power_ctrl[`CSC_PWR_OUT_EN];
            SPEAKER_OUT_N <= src_selected(DMA_MODE_ENABLE, DMA_REQ_SELECT, `CSC_REQ_SPKR) ?
                             1'b1 : pin_sync[`CSC_PIN_SPKR_N];
            MEM_WRITE_BLOCK <= WRITE_PROTECT_ENABLE && pin_sync[`CSC_PIN_WP_IOIS16_N];
        end
    end

    // Supply enables and programming selects
    always @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            LOW_SUPPLY_ENABLE_N   <= 1'b1;
            HIGH_SUPPLY_ENABLE_N  <= 1'b1;
            PROG_SUPPLY_SELECT_HI <= 1'b0;
            PROG_SUPPLY_SELECT_LO <= 1'b0;
        end
        else
        begin
            LOW_SUPPLY_ENABLE_N   <= vcc_n;
            HIGH_SUPPLY_ENABLE_N  <= vcc_n;
            PROG_SUPPLY_SELECT_HI <= vpp[1];
            PROG_SUPPLY_SELECT_LO <= vpp[0];
        end
    end

    // Narrow transfers carry the low byte only
    assign sized_data = WIDE_TRANSFER ? DMA_IN_DATA :
                        {{(DATA_WIDTH-8){1'b0}}, DMA_IN_DATA[7:0]};

    csc_fifo #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (SYS_CLK),
        .reset_n   (RESET_N),
        .in_data   (sized_data),
        .in_valid  (DMA_IN_VALID),
        .in_ready  (DMA_IN_READY),
        .out_data  (DMA_OUT_DATA),
        .out_valid (DMA_OUT_VALID),
        .out_ready (DMA_OUT_READY)
    );
endmodule // csc_slot_control

/* File: verif/csc_slot_control_properties.sv */
`timescale 1ns/1ps
module csc_slot_control_properties #(
    parameter [1:0] CARD_TYPES = 2'h2,
    parameter [3:0] REVISION   = 4'h1
) (
    input wire       SYS_CLK,
    input wire       RESET_N,
    input wire [7:0] REG_INDEX,
    input wire       REG_WRITE,
    input wire       REG_READ,
    input wire [7:0] REG_WDATA,
    input wire [7:0] REG_RDATA,
    input wire       DMA_MODE_ENABLE,
    input wire       MIXED_VOLTAGE,
    input wire       IRQ10_OE_N,
    input wire       CARD_OE_N,
    input wire       CARD_WE_N,
    input wire       CARD_REG_N,
    input wire       SLOT_OUT_EN_N,
    input wire       LOW_SUPPLY_ENABLE_N,
    input wire       HIGH_SUPPLY_ENABLE_N,
    input wire       PROG_SUPPLY_SELECT_HI,
    input wire       PROG_SUPPLY_SELECT_LO
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    wire       pwr_wr = REG_WRITE && REG_INDEX == 8'h02;
    wire [1:0] vpp    = {PROG_SUPPLY_SELECT_HI, PROG_SUPPLY_SELECT_LO};
    wire       en_n   = LOW_SUPPLY_ENABLE_N && HIGH_SUPPLY_ENABLE_N;
    property p_ident; REG_READ && REG_INDEX == 8'h00 |=> REG_RDATA == {CARD_TYPES, 2'h0, REVISION}; endproperty
    a_ident: assert property (p_ident) else $error("ident read wrong");
    property p_unmapped; REG_READ && REG_INDEX > 8'h02 |=> REG_RDATA == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_hold; !REG_READ |=> $stable(REG_RDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_dma_on; DMA_MODE_ENABLE [*2] |=> !IRQ10_OE_N; endproperty
    a_dma_on: assert property (p_dma_on) else $error("request pin not driven");
    property p_dma_off; !DMA_MODE_ENABLE [*2] |=> IRQ10_OE_N && CARD_OE_N && CARD_WE_N; endproperty
    a_dma_off: assert property (p_dma_off) else $error("dma pins active outside mode");
    property p_reg_high; DMA_MODE_ENABLE [*2] |=> CARD_REG_N; endproperty
    a_reg_high: assert property (p_reg_high) else $error("attribute strobe low in dma");
    property p_slot; pwr_wr |-> ##2 SLOT_OUT_EN_N == !$past(REG_WDATA[7], 2); endproperty
    a_slot: assert property (p_slot) else $error("slot enable wrong");
    property p_sup_off; pwr_wr && !REG_WDATA[4] && !REG_WDATA[5] |-> ##2 en_n && vpp == 2'h2; endproperty
    a_sup_off: assert property (p_sup_off) else $error("supply off decode wrong");
    property p_sup_on;
        pwr_wr && REG_WDATA[4] && !REG_WDATA[5] |-> ##2 LOW_SUPPLY_ENABLE_N == !$past(MIXED_VOLTAGE)
            && HIGH_SUPPLY_ENABLE_N == !$past(MIXED_VOLTAGE) && vpp == $past(REG_WDATA[1:0], 2);
    endproperty
    a_sup_on: assert property (p_sup_on) else $error("supply on decode wrong");
    c_dma: cover property (DMA_MODE_ENABLE && !IRQ10_OE_N);
    c_tc: cover property (!CARD_OE_N || !CARD_WE_N);
    c_pwr: cover property (pwr_wr && REG_WDATA[4]);
endmodule // csc_slot_control_properties
bind csc_slot_control csc_slot_control_properties #(.CARD_TYPES(CARD_TYPES), .REVISION(REVISION)) u_props (.*);

/* File: verif/csc_isa_dma_model.sv */
`timescale 1ns/1ps
module csc_isa_dma_model (
    input  wire clk,
    input  wire drq,
    input  wire drq_oe_n,
    input  wire tc_en,
    input  wire stall,
    input  wire slow,
    output reg  dack_n = 1'b1,
    output reg  tc_n = 1'b1,
    output reg  out_ready = 1'b0
);
    // Request counts only while the pin is driven
    wire req = drq && !drq_oe_n;
    always @(posedge clk)
    begin
        dack_n <= !req;
        tc_n <= !(req && tc_en);
        out_ready <= !stall && !(slow && out_ready);
    end
endmodule // csc_isa_dma_model

/* File: verif/tb_csc_slot_control.sv */
`timescale 1ns/1ps
module tb_csc_slot_control;
    localparam [1:0] CT = 2'h2;
    localparam [3:0] RV = 4'h5; // Arbitrary
    reg         SYS_CLK = 0, RESET_N = 0, REG_WRITE = 0, REG_READ = 0, DMA_MODE_ENABLE = 0;
    reg  [7:0]  REG_INDEX = 0, REG_WDATA = 0, p, v;
    reg  [1:0]  DMA_REQ_SELECT = 0;
    reg         TC_SELECT_IRQ15 = 0, IO_CARD = 0, RING_INDICATE_ENABLE = 0, WRITE_PROTECT_ENABLE = 0;
    reg         MIXED_VOLTAGE = 0, WIDE_TRANSFER = 1, DMA_CARD_READ = 0, NORMAL_REG_N = 0;
    reg         RESET_DRIVE = 0, POWER_GOOD = 1, DMA_IN_VALID = 0;
    reg  [15:0] DMA_IN_DATA = 0;
    reg  [8:0]  pins = 9'h1ff;
    reg         tc_route = 0, tc_en = 0, stall = 1, slow = 0, rd_d = 0, so, sw, dq, m, en;
    reg  [31:0] seed;
    integer     errors = 0, tests_run = 0, j, n, cnt;
    reg  [7:0]  rq[$];
    reg  [15:0] wq[$];
    wire [7:0]  REG_RDATA;
    wire [15:0] DMA_OUT_DATA;
    wire        IRQ10_OUT, IRQ10_OE_N, CARD_OE_N, CARD_WE_N, CARD_REG_N, SLOT_OUT_EN_N, SPEAKER_OUT_N;
    wire        MEM_WRITE_BLOCK, LOW_SUPPLY_ENABLE_N, HIGH_SUPPLY_ENABLE_N, PROG_SUPPLY_SELECT_HI;
    wire        PROG_SUPPLY_SELECT_LO, DMA_IN_READY, DMA_OUT_VALID, DMA_OUT_READY, dack_n, tc_n;
    wire        GENERAL_PURPOSE_INPUT = pins[0], CD1_N = pins[1], CD2_N = pins[2], READY_IREQ = pins[3];
    wire        WP_IOIS16_N = pins[4], SPKR_N = pins[5], INPACK_N = pins[6], BVD1_STSCHG = pins[7];
    wire        BVD2 = pins[8], IRQ9_IN = dack_n;
    wire        IRQ11_IN = tc_route | tc_n, IRQ15_IN = !tc_route | tc_n;
    always #2.5 SYS_CLK = !SYS_CLK;
    csc_slot_control #(.CARD_TYPES(CT), .REVISION(RV)) dut (.*);
    csc_isa_dma_model u_host (.clk(SYS_CLK), .drq(IRQ10_OUT), .drq_oe_n(IRQ10_OE_N), .tc_en(tc_en),
        .stall(stall), .slow(slow), .dack_n(dack_n), .tc_n(tc_n), .out_ready(DMA_OUT_READY));
    task finish_test;
    begin
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    task bail;
    begin
        errors = errors + 1;
        finish_test;
    end
    endtask
    task cmp_b(input [79:0] nm, input [7:0] e, input [7:0] g);
    begin
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            errors = errors + 1;
            $display("mismatch %0s exp %h got %h", nm, e, g);
        end
    end
    endtask
    task cmp_w(input [15:0] e, input [15:0] g);
    begin
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            errors = errors + 1;
            $display("mismatch fifo_data exp %h got %h", e, g);
        end
    end
    endtask
    task wr(input [7:0] i, input [7:0] d);
    begin
        @(negedge SYS_CLK);
        REG_INDEX = i;
        REG_WDATA = d;
        REG_WRITE = 1;
        @(negedge SYS_CLK);
        REG_WRITE = 0;
    end
    endtask
    task rd(input [7:0] i, input [7:0] e);
    begin
        rq.push_back(e);
        @(negedge SYS_CLK);
        REG_INDEX = i;
        REG_READ = 1;
        @(negedge SYS_CLK);
        REG_READ = 0;
    end
    endtask
    // Result watchers pair each answer with the oldest note
    always @(posedge SYS_CLK)
    begin
        rd_d <= REG_READ;
        if (DMA_OUT_VALID === 1'b1 && DMA_OUT_READY === 1'b1)
        begin
            if (wq.size() == 0)
                bail;
            else
                cmp_w(wq.pop_front(), DMA_OUT_DATA);
        end
    end
    always @(negedge SYS_CLK)
        if (rd_d)
        begin
            if (rq.size() == 0)
                bail;
            else
                cmp_b("rdata", rq.pop_front(), REG_RDATA);
        end
    initial
    begin
        seed = 32'h41d79a24;
        repeat (8) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        RESET_N = 1;
        rd(8'h00, {CT, 2'h0, RV});
        rd(8'h02, 8'h00);
        wr(8'h00, 8'hff);
        rd(8'h00, {CT, 2'h0, RV});
        rd(8'h07, 8'h00);
        for (j = 0; j < 16; j = j + 1)
        begin
            pins = $random(seed);
            {IO_CARD, RING_INDICATE_ENABLE, MIXED_VOLTAGE, WRITE_PROTECT_ENABLE, NORMAL_REG_N} = $random(seed);
            p = $random(seed);
            wr(8'h02, p);
            repeat (6) @(negedge SYS_CLK);
            m = p[5] && (pins[1] || pins[2]);
            en = m || !p[4] || !MIXED_VOLTAGE;
            v = m ? 8'h0 : p[4] ? p[1:0] : 8'h2;
            cmp_b("vcc_en", {en, en}, {LOW_SUPPLY_ENABLE_N, HIGH_SUPPLY_ENABLE_N});
            cmp_b("vpp_sel", v, {PROG_SUPPLY_SELECT_HI, PROG_SUPPLY_SELECT_LO});
            cmp_b("slot_en", !p[7], SLOT_OUT_EN_N);
            cmp_b("wr_block", WRITE_PROTECT_ENABLE & pins[4], MEM_WRITE_BLOCK);
            cmp_b("reg_n", NORMAL_REG_N, CARD_REG_N);
            cmp_b("spk_n", pins[5], SPEAKER_OUT_N);
            rd(8'h02, p);
            rd(8'h01, {!pins[0], !en, pins[3], pins[4], !pins[2], !pins[1], !IO_CARD & pins[8],
                pins[7] & !(IO_CARD & RING_INDICATE_ENABLE)});
        end
        for (j = 0; j < 3; j = j + 1)
        begin
            p = j == 1 ? 8'h15 : 8'h55;
            wr(8'h02, p);
            POWER_GOOD = j != 2;
            RESET_DRIVE = 1;
            repeat (4) @(negedge SYS_CLK);
            RESET_DRIVE = 0;
            repeat (6) @(negedge SYS_CLK);
            rd(8'h02, j == 0 ? p : 8'h00);
            POWER_GOOD = 1;
        end
        wr(8'h02, 8'h80);
        {IO_CARD, RING_INDICATE_ENABLE, pins} = {2'h2, 9'h1ef};
        DMA_REQ_SELECT = 1;
        repeat (6) @(negedge SYS_CLK);
        cmp_b("drq_oe_n", 8'h1, IRQ10_OE_N);
        pins[4] = 1;
        DMA_MODE_ENABLE = 1;
        for (j = 0; j < 12; j = j + 1)
        begin
            DMA_REQ_SELECT = j % 3 + 1;
            {TC_SELECT_IRQ15, tc_route, DMA_CARD_READ} = $random(seed);
            pins[3 + DMA_REQ_SELECT] = 0;
            tc_en = 1;
            {dq, so, sw} = 3'h0;
            repeat (12)
            begin
                @(negedge SYS_CLK);
                dq = dq | IRQ10_OUT === 1'b1;
                so = so | CARD_OE_N === 1'b0;
                sw = sw | CARD_WE_N === 1'b0;
            end
            m = tc_route == TC_SELECT_IRQ15;
            cmp_b("drq", 8'h1, dq);
            cmp_b("tc_oe", m & DMA_CARD_READ, so);
            cmp_b("tc_we", m & !DMA_CARD_READ, sw);
            cmp_b("dma_pins", 8'h1, {IRQ10_OE_N, CARD_REG_N});
            if (DMA_REQ_SELECT == 2)
                cmp_b("spk_n", 8'h1, SPEAKER_OUT_N);
            if (DMA_REQ_SELECT == 1)
                rd(8'h01, 8'h31);
            pins[3 + DMA_REQ_SELECT] = 1;
            tc_en = 0;
            repeat (8) @(negedge SYS_CLK);
        end
        DMA_MODE_ENABLE = 0;
        for (j = 0; j < 2; j = j + 1)
        begin
            WIDE_TRANSFER = !j;
            stall = 1;
            cnt = 0;
            dq = 1;
            for (n = 0; n < 40; n = n + 1)
            begin
                @(negedge SYS_CLK);
                if (dq)
                    DMA_IN_DATA = $random(seed);
                DMA_IN_VALID = 1;
                dq = DMA_IN_READY === 1'b1;
                @(posedge SYS_CLK);
                if (dq)
                    wq.push_back(WIDE_TRANSFER ? DMA_IN_DATA : {8'h00, DMA_IN_DATA[7:0]});
                cnt = cnt + dq;
            end
            @(negedge SYS_CLK);
            DMA_IN_VALID = 0;
            cmp_b("fill", 8'd33, cnt);
            stall = 0;
            slow = j;
            for (n = 0; n < 200 && wq.size() > 0; n = n + 1)
                @(negedge SYS_CLK);
            if (wq.size() > 0)
                errors = errors + 1;
        end
        finish_test;
    end
endmodule // tb_csc_slot_control
